// ---- verification/thermal_sensor_config_register_tb_top.sv ----
`timescale 1ns/1ps
module thermal_sensor_config_register_tb_top;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  wire cfg_wr, wa, ca, sd;
  wire [15:0] cfg_wdata, cfg_rdata;
  reg tv = 1'b0;
  reg [12:0] tval = 13'h0000;
  wire ab_crit, ab_win, bl_win, a_out, a_oe;
  integer miscompares = 0;
  integer comparisons = 0;
  logic [31:0] rows [0:5] = '{32'h060F060F, 32'hF8300000, 32'h01000100,
    32'h00000000, 32'h02000200, 32'h04000400};
  initial forever #2 clock = ~clock;
  tsc_host i_host (.clock(clock), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata));
  tsc_config i_dut (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .temp_valid(tv),
    .temp_value(tval), .upper_limit(13'h0100), .lower_limit(13'h0000),
    .crit_limit(13'h0500), .window_wr_allow(wa), .crit_wr_allow(ca),
    .sensor_shutdown(sd), .above_crit(ab_crit), .above_window(ab_win),
    .below_window(bl_win), .alert_out(a_out), .alert_oe(a_oe));
  task check(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] d, input [15:0] e);
    begin
      i_host.write(d);
      check(cfg_rdata, e);
    end
  endtask
  task temp(input [12:0] v);
    begin
      @(negedge clock);
      tval = v;
      tv = 1'b1;
      @(negedge clock);
      tv = 1'b0;
    end
  endtask
  task stop_test;
    begin
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    check({13'h0000, wa, ca, sd}, 16'h0006);
    for (int i = 0; i < 6; i++) wr(rows[i][31:16], rows[i][15:0]);
    wr(16'h0108, 16'h0108);
    check({13'h0000, wa, ca, sd}, 16'h0007);
    wr(16'h0148, 16'h0148);
    wr(16'h0047, 16'h0048);
    wr(16'h0180, 16'h00C8);
    wr(16'h0000, 16'h00C8);
    check({13'h0000, wa, ca, sd}, 16'h0000);
    rst_n = 1'b0;
    #1;
    check(cfg_rdata | {13'h0000, wa, ca, sd}, 16'h0006);
    @(negedge clock);
    rst_n = 1'b1;
    wr(16'h040A, 16'h040A);
    temp(13'h0110);
    check({15'h0000, ab_win}, 16'h0001);
    check(cfg_rdata & 16'h0010, 16'h0010);
    @(negedge clock);
    check({14'h0000, a_oe, a_out}, 16'h0003);
    temp(13'h00F0);
    check({15'h0000, ab_win}, 16'h0001);
    temp(13'h0500);
    check({15'h0000, ab_crit}, 16'h0001);
    temp(13'h00D0);
    check({14'h0000, ab_crit, ab_win}, 16'h0000);
    @(negedge clock);
    check({15'h0000, a_out}, 16'h0000);
    wr(16'h040B, 16'h040B);
    temp(13'h1F00);
    @(negedge clock);
    check({15'h0000, bl_win}, 16'h0001);
    check(cfg_rdata, 16'h041B);
    wr(16'h042B, 16'h040B);
    stop_test;
  end
  initial begin
    #100000;
    miscompares = miscompares + 1;
    stop_test;
  end
endmodule

// ---- verification/tsc_config_props.sv ----
`timescale 1ns/1ps
// ====
// config register checks
module tsc_config_props (
  input wire clock,
  input wire rst_n,
  input wire cfg_wr,
  input wire [15:0] cfg_wdata,
  input wire [15:0] cfg_rdata,
  input wire window_wr_allow,
  input wire crit_wr_allow,
  input wire sensor_shutdown,
  input wire alert_out,
  input wire alert_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire lk = |cfg_rdata[7:6];
  AST_RSV: assert property (cfg_rdata[15:11] == 0 && !cfg_rdata[5])
    else $error("reserved bits set");
  AST_WL: assert property (window_wr_allow != cfg_rdata[6])
    else $error("window allow wrong");
  AST_CL: assert property (crit_wr_allow != cfg_rdata[7])
    else $error("crit allow wrong");
  AST_SD: assert property (sensor_shutdown == cfg_rdata[8])
    else $error("shutdown out wrong");
  AST_STK: assert property (lk |=> (cfg_rdata[7:6] & $past(cfg_rdata[7:6])) == $past(cfg_rdata[7:6]))
    else $error("lock cleared");
  AST_OE: assert property (alert_oe == $past(cfg_rdata[3]))
    else $error("alert enable wrong");
  AST_IDLE: assert property (!cfg_rdata[3] && !cfg_wr |=> alert_out != cfg_rdata[1])
    else $error("disabled alert pin active");
  AST_ARM: assert property (cfg_wr && cfg_wdata[7] |=> cfg_rdata[7])
    else $error("lock not armed");
  AST_FRZ: assert property (cfg_wr && lk |=> $stable(cfg_rdata[3:0] & 4'hB))
    else $error("locked bit changed");
  AST_NSD: assert property (cfg_wr && lk && !cfg_rdata[8] |=> !cfg_rdata[8])
    else $error("shutdown set under lock");
  AST_SDC: assert property (cfg_wr && !cfg_wdata[8] |=> !cfg_rdata[8])
    else $error("shutdown not cleared");
endmodule
bind tsc_config tsc_config_props i_props (.clock(clock), .rst_n(rst_n),
  .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .window_wr_allow(window_wr_allow), .crit_wr_allow(crit_wr_allow),
  .sensor_shutdown(sensor_shutdown), .alert_out(alert_out),
  .alert_oe(alert_oe));

// ---- verification/tsc_host.sv ----
`timescale 1ns/1ps
// ====
// host end of the register write path
module tsc_host (
  input wire clock,
  output reg cfg_wr = 1'b0,
  output reg [15:0] cfg_wdata = 16'h0000
);
  // trip causes come from the temperature register, not this one
  task write(input [15:0] d);
    begin
      @(negedge clock);
      cfg_wr = 1'b1;
      cfg_wdata = d;
      @(negedge clock);
      cfg_wr = 1'b0;
      cfg_wdata = ~d; // idle bus shows no stale word
    end
  endtask
endmodule

// ---- verilog/tsc_config.v ----
`timescale 1ns/1ps
// Overview of operation
// - sixteen-bit register, zero after power-on reset
// - bit 0 picks comparator or interrupt mode
// - bit 1 polarity; locked by either lock
// - bit 2 selects critical-only alert source
// - window lock freezes critical-only bit
// - bit 3 alert enable; locked by either lock
// - bit 4 reads alert status: live condition in comparator mode, latched interrupt in interrupt mode
// - writes to status bit do nothing
// - writing one to bit 5 clears interrupt
// - bit 5 reads zero; comparator ignores it
// - window lock rejects window limit writes
// - window lock sticky until power-on reset
// - critical lock rejects critical limit writes
// - critical lock sticky until power-on reset
// - single write arms a lock
// - shutdown stops conversion and masks the alert condition, but not an interrupt already pending
// - shutdown cannot be set while locked
// - shutdown clears anytime and at reset
// - bits 10:9 choose hysteresis amount
// - hysteresis applies at every trip threshold
// - bits 15:11 read zero
// - above-window flag sets above, clears at limit-hyst
module tsc_config (
  clock,
  rst_n,
  cfg_wr,
  cfg_wdata,
  cfg_rdata,
  temp_valid,
  temp_value,
  upper_limit,
  lower_limit,
  crit_limit,
  window_wr_allow,
  crit_wr_allow,
  sensor_shutdown,
  above_crit,
  above_window,
  below_window,
  alert_out,
  alert_oe
);
`include "tsc_regs.vh"
  input wire clock;
  input wire rst_n;
  input wire cfg_wr;
  input wire [15:0] cfg_wdata;
  output wire [15:0] cfg_rdata;
  input wire temp_valid;
  input wire [12:0] temp_value;
  input wire [12:0] upper_limit;
  input wire [12:0] lower_limit;
  input wire [12:0] crit_limit;
  output wire window_wr_allow;
  output wire crit_wr_allow;
  output wire sensor_shutdown;
  output reg above_crit;
  output reg above_window;
  output reg below_window;
  output reg alert_out;
  output reg alert_oe;

  // ==========================================
  // configuration fields
  reg mode_q;
  reg pol_q;
  reg crit_only_q;
  reg alert_en_q;
  reg win_lock_q;
  reg crit_lock_q;
  reg shutdown_q;
  reg [1:0] hyst_q;
  reg irq_pend_q;
  wire any_lock;
  wire [12:0] hyst;
  wire cond;
  wire clear_req;

  // signed compare of 13-bit two's-complement temperatures
  function lt13;
    input [12:0] a;
    input [12:0] b;
    begin
      lt13 = $signed(a) < $signed(b);
    end
  endfunction

  function [12:0] hyst_amt;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: hyst_amt = `TSC_HYST_1P5;
        2'h2: hyst_amt = `TSC_HYST_3;
        2'h3: hyst_amt = `TSC_HYST_6;
        default: hyst_amt = `TSC_HYST_0;
      endcase
    end
  endfunction

  assign any_lock = win_lock_q | crit_lock_q;
  assign hyst = hyst_amt(hyst_q);
  assign window_wr_allow = ~win_lock_q;
  assign crit_wr_allow = ~crit_lock_q;
  assign sensor_shutdown = shutdown_q;
  // clear only counts in interrupt mode; comparator mode drops it
  assign clear_req = cfg_wr & cfg_wdata[`TSC_BIT_CLEAR] &
    mode_q;

  // ==========================================
  // register writes
  reg mode_d;
  reg pol_d;
  reg crit_only_d;
  reg alert_en_d;
  reg win_lock_d;
  reg crit_lock_d;
  reg shutdown_d;
  reg [1:0] hyst_d;

  // status and clear bits have no storage, so a write to them is not held here
  always @* begin
    mode_d = mode_q;
    pol_d = pol_q;
    crit_only_d = crit_only_q;
    alert_en_d = alert_en_q;
    win_lock_d = win_lock_q;
    crit_lock_d = crit_lock_q;
    shutdown_d = shutdown_q;
    hyst_d = hyst_q;
    if (cfg_wr) begin
      if (!any_lock) begin
        mode_d = cfg_wdata[`TSC_BIT_MODE];
        pol_d = cfg_wdata[`TSC_BIT_POL];
        alert_en_d = cfg_wdata[`TSC_BIT_ALERT_EN];
      end
      if (!win_lock_q) begin
        crit_only_d = cfg_wdata[`TSC_BIT_CRIT_ONLY];
      end
      // locks only ever set, one write suffices
      if (cfg_wdata[`TSC_BIT_WIN_LOCK]) begin
        win_lock_d = 1'b1;
      end
      if (cfg_wdata[`TSC_BIT_CRIT_LOCK]) begin
        crit_lock_d = 1'b1;
      end
      // clearing is always allowed, setting only while unlocked
      if (!cfg_wdata[`TSC_BIT_SHUTDOWN]) begin
        shutdown_d = 1'b0;
      end else if (!any_lock) begin
        shutdown_d = 1'b1;
      end
      hyst_d = cfg_wdata[`TSC_BIT_HYST_HI:`TSC_BIT_HYST_LO];
    end
  end

  // locks can only be cleared here, by the power-on reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
      pol_q <= 1'b0;
      crit_only_q <= 1'b0;
      alert_en_q <= 1'b0;
      win_lock_q <= 1'b0;
      crit_lock_q <= 1'b0;
      shutdown_q <= 1'b0;
      hyst_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      pol_q <= pol_d;
      crit_only_q <= crit_only_d;
      alert_en_q <= alert_en_d;
      win_lock_q <= win_lock_d;
      crit_lock_q <= crit_lock_d;
      shutdown_q <= shutdown_d;
      hyst_q <= hyst_d;
    end
  end

  // ==========================================
  // trip flags with hysteresis, frozen in shutdown
  reg above_crit_d;
  reg above_window_d;
  reg below_window_d;
  wire [12:0] upper_clear;
  wire [12:0] lower_set;
  wire [12:0] crit_clear;
  wire take_sample;

  // threshold minus hysteresis wraps if a limit sits near the bottom
  // of the range; limits are expected to stay well inside it
  assign upper_clear = upper_limit - hyst;
  assign lower_set = lower_limit - hyst;
  assign crit_clear = crit_limit - hyst;
  assign take_sample = temp_valid & ~shutdown_q;

  always @* begin
    above_crit_d = above_crit;
    above_window_d = above_window;
    below_window_d = below_window;
    if (take_sample) begin
      if (lt13(upper_limit, temp_value)) begin
        above_window_d = 1'b1;
      end else if (!lt13(upper_clear, temp_value)) begin
        above_window_d = 1'b0;
      end
      if (lt13(temp_value, lower_set)) begin
        below_window_d = 1'b1;
      end else if (!lt13(temp_value, lower_limit)) begin
        below_window_d = 1'b0;
      end
      // critical trips at equality, unlike the window flags
      if (!lt13(temp_value, crit_limit)) begin
        above_crit_d = 1'b1;
      end else if (lt13(temp_value, crit_clear)) begin
        above_crit_d = 1'b0;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      above_crit <= 1'b0;
      above_window <= 1'b0;
      below_window <= 1'b0;
    end else begin
      above_crit <= above_crit_d;
      above_window <= above_window_d;
      below_window <= below_window_d;
    end
  end

  // ==========================================
  // alert condition and pin
  assign cond = !shutdown_q && (crit_only_q ? above_crit :
    (above_crit | above_window | below_window));

  // interrupt latch: a new rising condition outranks a same-cycle clear
  reg cond_q;
  reg irq_pend_d;
  always @* begin
    irq_pend_d = irq_pend_q;
    if (cond && !cond_q) begin
      irq_pend_d = 1'b1;
    end else if (clear_req || !mode_q) begin
      irq_pend_d = 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= 1'b0;
      irq_pend_q <= 1'b0;
    end else begin
      cond_q <= cond;
      irq_pend_q <= irq_pend_d;
    end
  end

  wire active = mode_q ? irq_pend_q : cond;

  // open-drain style pin: drives only while enabled
  reg alert_out_d;
  reg alert_oe_d;
  always @* begin
    alert_oe_d = alert_en_q;
    if (alert_en_q && active) begin
      alert_out_d = pol_q;
    end else begin
      alert_out_d = ~pol_q;
    end
  end

  // pin lags the alert status by one cycle (condition, or pending interrupt in interrupt mode); registered to avoid glitches
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= alert_oe_d;
      alert_out <= alert_out_d;
    end
  end

  // ==========================================
  // readback; clear and reserved bits read zero
  reg [15:0] rdata_c;
  always @* begin
    rdata_c = `TSC_CFG_RESET;
    rdata_c[`TSC_BIT_MODE] = mode_q;
    rdata_c[`TSC_BIT_POL] = pol_q;
    rdata_c[`TSC_BIT_CRIT_ONLY] = crit_only_q;
    rdata_c[`TSC_BIT_ALERT_EN] = alert_en_q;
    rdata_c[`TSC_BIT_STATUS] = active;
    rdata_c[`TSC_BIT_CLEAR] = 1'b0;
    rdata_c[`TSC_BIT_WIN_LOCK] = win_lock_q;
    rdata_c[`TSC_BIT_CRIT_LOCK] = crit_lock_q;
    rdata_c[`TSC_BIT_SHUTDOWN] = shutdown_q;
    rdata_c[`TSC_BIT_HYST_HI:`TSC_BIT_HYST_LO] = hyst_q;
  end

  assign cfg_rdata = rdata_c;
endmodule

// ---- verilog/tsc_regs.vh ----
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
// ==========================================
// register index and reset
`define TSC_CFG_INDEX 3'h1
`define TSC_CFG_RESET 16'h0000
// ==========================================
// field positions
`define TSC_BIT_MODE 0
`define TSC_BIT_POL 1
`define TSC_BIT_CRIT_ONLY 2
`define TSC_BIT_ALERT_EN 3
`define TSC_BIT_STATUS 4
`define TSC_BIT_CLEAR 5
`define TSC_BIT_WIN_LOCK 6
`define TSC_BIT_CRIT_LOCK 7
`define TSC_BIT_SHUTDOWN 8
`define TSC_BIT_HYST_LO 9
`define TSC_BIT_HYST_HI 10
// ==========================================
// hysteresis in temperature lsbs of 0.0625 degC
`define TSC_HYST_0 13'h0000
`define TSC_HYST_1P5 13'h0018
`define TSC_HYST_3 13'h0030
`define TSC_HYST_6 13'h0060
`endif
